// ### src/pfrw_top.sv
`timescale 1ns/1ns
module pfrw_top
	import pfrw_pkg::*;
#(
	parameter int WRITE_CYCLES_P = WRITE_CYCLES,
	parameter int ERASE_CYCLES_P = WRITE_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire pfrw_pkg::pfrw_bus_type bus,
	output logic      [7:0]        rdata,
	output logic                   cpu_stall,
	output logic                   busy
);
	import pfrw_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	pfrw_state_type    state_q, state_d;
	logic [7:0]        ctrl_q;
	logic [ADDR_W-1:0] ptr_q;
	logic [1:0]        key_q;      // 0 none, 1 first key seen, 2 unlocked
	logic [31:0]       timer_q;
	logic [2:0]        idx_q;      // byte index within group during commit
	logic              ack_q;      // read strobe seen last cycle
	logic [3:0]        raddr_q;
	logic              wrerr_q;
	logic [7:0]        hold_rd;
	logic [7:0]        flash_rd;
	pfrw_mem_wr_type   mem_wr;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	wire idle      = (state_q == PFRW_IDLE);
	wire wr_ctrl   = bus.wr && bus.addr == ADDR_CTRL && idle;
	wire wr_key    = bus.wr && bus.addr == ADDR_KEY && idle;
	wire wr_latch  = bus.wr && bus.addr == ADDR_LATCH && idle;
	wire wr_ptr_lo = bus.wr && bus.addr == ADDR_PTR_LO && idle;
	wire wr_ptr_hi = bus.wr && bus.addr == ADDR_PTR_HI && idle;
	wire rd_flash  = bus.rd && bus.addr == ADDR_RDATA && idle;
	// permit is taken from the value that carries the start bit, not from the stored copy
	wire permit    = bus.wdata[CTRL_PERMIT_BIT];
	wire unlocked  = (key_q == 2'd2);
	// start honoured only right after the key pair with permit set
	wire start_req = wr_ctrl && bus.wdata[CTRL_START_BIT];
	wire start_ok  = start_req && unlocked && permit;
	// program space only; config space selection blocks the commit
	wire prog_sel  = bus.wdata[CTRL_MEM_BIT] && !bus.wdata[CTRL_CFG_BIT];
	wire do_write  = start_ok && prog_sel && !bus.wdata[CTRL_ERASE_BIT];
	wire do_erase  = start_ok && prog_sel && bus.wdata[CTRL_ERASE_BIT];
	wire timer_end = (timer_q == 32'd0);
	// holding read is registered, so it is addressed one step ahead of the write index
	wire [2:0] idx_next = idle ? 3'd0
		: (idx_q != 3'(GROUP_BYTES - 1)) ? idx_q + 3'd1 : idx_q;
	wire [ADDR_W-1:0] group_base = {ptr_q[ADDR_W-1:3] - 1'b1, 3'b000};
	wire [ADDR_W-1:0] row_base   = {ptr_q[ADDR_W-1:6], 6'b000000};

	// ----------------------------------------------------------------
	// sequencer: stalls the cpu for the timed erase or write
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PFRW_IDLE: begin
				if (do_write) begin
					state_d = PFRW_WRITE;
				end else if (do_erase) begin
					state_d = PFRW_ERASE;
				end
			end
			PFRW_ERASE, PFRW_WRITE: begin
				if (timer_end) begin
					state_d = PFRW_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= PFRW_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// interval timer; eight passes plus erase give the row time
	always_ff @(posedge clk) begin
		if (rst) begin
			timer_q <= 32'd0;
		end else if (do_write) begin
			timer_q <= 32'(WRITE_CYCLES_P - 1);
		end else if (do_erase) begin
			timer_q <= 32'(ERASE_CYCLES_P - 1);
		end else if (!idle && !timer_end) begin
			timer_q <= timer_q - 32'd1;
		end
	end

	// ----------------------------------------------------------------
	// unlock key tracker: any other bus write breaks the sequence
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			key_q <= 2'd0;
		end else if (wr_key && bus.wdata == KEY_FIRST) begin
			key_q <= 2'd1;
		end else if (wr_key && bus.wdata == KEY_SECOND && key_q == 2'd1) begin
			key_q <= 2'd2;
		end else if (bus.wr) begin
			key_q <= 2'd0;
		end
	end

	// control register; start self-clears when the cycle ends, erase keeps its written value
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
		end else if (wr_ctrl) begin
			ctrl_q <= bus.wdata;
			ctrl_q[CTRL_START_BIT] <= start_ok && prog_sel;
		end else if (!idle && timer_end) begin
			ctrl_q[CTRL_START_BIT] <= 1'b0;
		end
	end

	// rejected start flag, cleared by the next accepted start
	always_ff @(posedge clk) begin
		if (rst) begin
			wrerr_q <= 1'b0;
		end else if (start_req && !(start_ok && prog_sel)) begin
			wrerr_q <= 1'b1;
		end else if (start_ok) begin
			wrerr_q <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// table pointer: auto-increment on staging and on table reads
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_q <= '0;
		end else if (wr_ptr_lo) begin
			ptr_q[7:0] <= bus.wdata;
		end else if (wr_ptr_hi) begin
			ptr_q[ADDR_W-1:8] <= bus.wdata[ADDR_W-9:0];
		end else if (wr_latch || rd_flash) begin
			ptr_q <= ptr_q + 1'b1;
		end
	end

	// commit walk: one staged byte per cycle at the start of the write
	always_ff @(posedge clk) begin
		if (rst || idle) begin
			idx_q <= 3'd0;
		end else if (idx_q != 3'(GROUP_BYTES - 1)) begin
			idx_q <= idx_q + 3'd1;
		end
	end

	// write port: staged bytes during write, all ones over the row on erase
	assign mem_wr.we   = (state_q == PFRW_WRITE && ctrl_q[CTRL_START_BIT] && !timer_end)
		|| (state_q == PFRW_ERASE);
	assign mem_wr.addr = (state_q == PFRW_ERASE) ? row_base | ADDR_W'(timer_q[5:0])
		: group_base | ADDR_W'(idx_q);
	assign mem_wr.data = (state_q == PFRW_ERASE) ? 8'hFF : hold_rd;

	pfrw_hold #(
		.DEPTH (GROUP_BYTES)
	) u_hold (
		.clk   (clk),
		.rst   (rst),
		.we    (wr_latch),
		.waddr (ptr_q[2:0]),
		.wdata (bus.wdata),
		.raddr (idx_next),
		.rdata (hold_rd)
	);

	pfrw_flash #(
		.ADDR_W (ADDR_W)
	) u_flash (
		.clk   (clk),
		.we    (mem_wr.we),
		.waddr (mem_wr.addr),
		.wdata (mem_wr.data),
		.raddr (ptr_q),
		.rdata (flash_rd)
	);

	// ----------------------------------------------------------------
	// read path: data one cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_q   <= 1'b0;
			raddr_q <= 4'h0;
		end else begin
			ack_q   <= bus.rd;
			raddr_q <= bus.addr;
		end
	end

	always_comb begin
		rdata = 8'h00;
		if (ack_q) begin
			unique case (raddr_q)
				ADDR_CTRL:   rdata = ctrl_q;
				ADDR_PTR_LO: rdata = ptr_q[7:0];
				ADDR_PTR_HI: rdata = 8'(ptr_q[ADDR_W-1:8]);
				ADDR_STATUS: rdata = {5'h00, wrerr_q, unlocked, !idle};
				ADDR_RDATA:  rdata = flash_rd;
				default:     rdata = 8'h00;
			endcase
		end
	end

	assign cpu_stall = !idle;
	assign busy      = !idle;
endmodule

// ### src/pfrw_pkg.sv
package pfrw_pkg;

	// ----------------------------------------------------------------
	// register map (byte-wide registers, word index = offset)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_CTRL   = 4'h0; // memory_write_control
	localparam logic [3:0] ADDR_KEY    = 4'h1; // unlock_key_port
	localparam logic [3:0] ADDR_PTR_LO = 4'h2;
	localparam logic [3:0] ADDR_PTR_HI = 4'h3;
	localparam logic [3:0] ADDR_LATCH  = 4'h4; // stage byte, pointer advances
	localparam logic [3:0] ADDR_STATUS = 4'h5;
	localparam logic [3:0] ADDR_RDATA  = 4'h6; // table read, pointer advances

	// ----------------------------------------------------------------
	// control bit positions
	// ----------------------------------------------------------------
	localparam int CTRL_START_BIT  = 1;
	localparam int CTRL_PERMIT_BIT = 2;
	localparam int CTRL_ERASE_BIT  = 4;
	localparam int CTRL_CFG_BIT    = 6;
	localparam int CTRL_MEM_BIT    = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// unlock key and geometry
	// ----------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam int GROUP_BYTES = 8;
	localparam int ROW_BYTES   = 64;
	localparam int ADDR_W      = 14;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 50_000_000;
	localparam int WRITE_TIME_US = 2000;
	localparam int WRITE_CYCLES  = (CLK_HZ / 1_000_000) * WRITE_TIME_US;
	localparam int ROW_TIME_US   = 18000;

	typedef enum logic [1:0] {
		PFRW_IDLE,
		PFRW_ERASE,
		PFRW_WRITE
	} pfrw_state_type;

	// register bus request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} pfrw_bus_type;

	// flash array write port
	typedef struct packed {
		logic              we;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        data;
	} pfrw_mem_wr_type;

endpackage

// ### src/pfrw_hold.sv
`timescale 1ns/1ns
// eight-byte write holding registers
module pfrw_hold #(
	parameter int DEPTH = 8
) (
	input  wire logic                     clk,
	input  wire logic                     rst,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] waddr,
	input  wire logic [7:0]               wdata,
	input  wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic      [7:0]               rdata
);
	logic [7:0] mem_q [DEPTH];

	// holding latches reset to erased value so bytes unstaged since reset write all ones
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= 8'hFF;
			end
		end else if (we) begin
			mem_q[waddr] <= wdata;
		end
	end

	// registered read data
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem_q[raddr];
		end
	end
endmodule

// ### src/pfrw_flash.sv
`timescale 1ns/1ns
// behavioural flash array with registered read
module pfrw_flash #(
	parameter int ADDR_W = 14
) (
	input  wire logic              clk,
	input  wire logic              we,
	input  wire logic [ADDR_W-1:0] waddr,
	input  wire logic [7:0]        wdata,
	input  wire logic [ADDR_W-1:0] raddr,
	output logic      [7:0]        rdata
);
	logic [7:0] mem_q [2**ADDR_W];

	// array contents are not reset; flash keeps its data
	always_ff @(posedge clk) begin
		if (we) begin
			mem_q[waddr] <= wdata;
		end
		rdata <= mem_q[raddr];
	end
endmodule

// ### verification/pfrw_assertions.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// bus-side checker for the row writer
// ----------------------------------------------------------------
module pfrw_assertions
	import pfrw_pkg::*;
#(
	parameter int WRITE_CYCLES_P = 16,
	parameter int ERASE_CYCLES_P = 64
) (
	input wire logic                   clk,
	input wire logic                   rst,
	input wire pfrw_pkg::pfrw_bus_type bus,
	input wire logic [7:0]             rdata,
	input wire logic                   cpu_stall,
	input wire logic                   busy
);
	localparam int MAX_STALL = (WRITE_CYCLES_P > ERASE_CYCLES_P) ? WRITE_CYCLES_P : ERASE_CYCLES_P;
	logic        k1_q;
	logic        k2_q;
	logic [31:0] run_q;
	// start is legal only when the last two writes were the key pair
	wire start_try = bus.wr && bus.addr == ADDR_CTRL && bus.wdata[CTRL_START_BIT];
	wire perm_ok   = bus.wdata[CTRL_PERMIT_BIT] && bus.wdata[CTRL_MEM_BIT] && !bus.wdata[CTRL_CFG_BIT];
	wire start_ok  = start_try && perm_ok && k2_q;
	// key tracker and stall length counter
	always_ff @(posedge clk) begin
		if (rst) begin
			k1_q <= 1'b0;
			k2_q <= 1'b0;
		end else if (bus.wr) begin
			k1_q <= bus.addr == ADDR_KEY && bus.wdata == KEY_FIRST;
			k2_q <= k1_q && bus.addr == ADDR_KEY && bus.wdata == KEY_SECOND;
		end
	end
	always_ff @(posedge clk) begin
		run_q <= (rst || !busy) ? 32'h0 : run_q + 32'h1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_RESET_IDLE: assert property ($past(rst) |-> !busy && rdata == 8'h00) else $error("not idle after reset");
	AST_RDATA_QUIET: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("rdata outside read slot");
	AST_STALL_SAME: assert property (cpu_stall == busy) else $error("stall and busy differ");
	AST_START_TAKEN: assert property (start_ok && !busy |=> busy) else $error("armed start ignored");
	AST_START_REFUSED: assert property (start_try && !start_ok && !busy |=> !busy) else $error("bad start taken");
	AST_STALL_CAUSE: assert property ($rose(busy) |-> $past(start_ok)) else $error("stall without unlock");
	AST_STALL_MIN: assert property ($rose(busy) |-> busy [*8]) else $error("stall too short");
	AST_STALL_MAX: assert property (run_q <= MAX_STALL) else $error("stall too long");
	COV_START: cover property (start_ok && !busy);
	COV_REFUSE: cover property (start_try && !start_ok);
	COV_READ: cover property ($past(bus.rd) && rdata != 8'h00);
endmodule

bind pfrw_top pfrw_assertions #(.WRITE_CYCLES_P(WRITE_CYCLES_P), .ERASE_CYCLES_P(ERASE_CYCLES_P)) i_chk (
	.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .cpu_stall(cpu_stall), .busy(busy));

// ### verification/pfrw_cpu_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// processor side: one-cycle strobes, changed right after an edge
// ----------------------------------------------------------------
module pfrw_cpu_model
	import pfrw_pkg::*;
(
	input  wire logic             clk,
	output pfrw_pkg::pfrw_bus_type bus
);
	initial bus = '0;
	// single write, idle cycle after it
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	// single read, data lands in the idle cycle
	task automatic rd(input logic [3:0] a);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask
	// key pair then control back to back, so no stray write splits them
	task automatic unlock(input logic [7:0] c);
		bus <= '{addr: ADDR_KEY, wdata: KEY_FIRST, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '{addr: ADDR_KEY, wdata: KEY_SECOND, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '{addr: ADDR_CTRL, wdata: c, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
endmodule

// ### verification/pfrw_top_tb.sv
`timescale 1ns/1ns
module pfrw_top_tb;
	import pfrw_pkg::*;
	localparam int WC = 16;
	localparam int EC = 64;
	logic         clk;
	logic         rst;
	pfrw_bus_type bus;
	logic [7:0]   rdata;
	logic         cpu_stall;
	logic         busy;
	logic [7:0]   row [64];
	logic [7:0]   exp_q [$];
	logic [7:0]   msk_q [$];
	logic [7:0]   bad [3] = '{8'h82, 8'h06, 8'hC6};
	logic         rd_d = 1'b0;
	int           fails = 0;
	int           compares = 0;
	int           seed = 57704;
	int           n;
	initial clk = 1'b0;
	always #10 clk = ~clk;
	pfrw_cpu_model i_cpu (.clk(clk), .bus(bus));
	pfrw_top #(.WRITE_CYCLES_P(WC), .ERASE_CYCLES_P(EC)) i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
		.cpu_stall(cpu_stall), .busy(busy));
	// ----------------------------------------------------------------
	// compare and closing tasks
	// ----------------------------------------------------------------
	task automatic check_byte(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
		compares++;
		if (((got ^ e) & m) !== 8'h00) begin
			fails++;
			$display("[FAIL] %0t read %h expected %h", $time, got, e);
		end
	endtask
	task automatic check_len(input int got, input int e);
		compares++;
		if (got != e) begin
			fails++;
			$display("[FAIL] %0t stall %0d expected %0d", $time, got, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("fails=%0d compares=%0d", fails, compares);
		if (fails == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// count stall cycles; bounded so a stuck stall cannot hang the run
	task automatic stall_wait;
		n = 0;
		#1;
		while (busy !== 1'b0 && n < 500) begin
			@(posedge clk);
			#1;
			n++;
		end
	endtask
	task automatic rd_exp(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
		exp_q.push_back(e);
		msk_q.push_back(m);
		i_cpu.rd(a);
	endtask
	// ----------------------------------------------------------------
	// monitor: read data stands only in the cycle after the strobe
	// ----------------------------------------------------------------
	always @(posedge clk) rd_d <= bus.rd;
	always @(negedge clk) begin
		if (rd_d) begin
			if (exp_q.size() == 0)
				check_byte(rdata, 8'h00, 8'h00);
			else
				check_byte(rdata, exp_q.pop_front(), msk_q.pop_front());
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
	// main sequence: refusals first, then a full row update
	initial begin
		rst = 1'b1;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_exp(ADDR_STATUS, 8'h00, 8'h07);
		i_cpu.wr(ADDR_CTRL, 8'h86);
		stall_wait();
		check_len(n, 0);
		rd_exp(ADDR_STATUS, 8'h04, 8'h04);
		foreach (bad[i]) begin
			i_cpu.unlock(bad[i]);
			stall_wait();
			check_len(n, 0);
		end
		i_cpu.wr(ADDR_PTR_LO, 8'h00);
		i_cpu.wr(ADDR_PTR_HI, 8'h00);
		i_cpu.unlock(8'h96);
		stall_wait();
		check_len(n, EC);
		// row image kept here, as software keeps its RAM copy
		for (int g = 0; g < 8; g++) begin
			for (int b = 0; b < 8; b++) begin
				row[g * 8 + b] = 8'($random(seed));
				i_cpu.wr(ADDR_LATCH, row[g * 8 + b]);
			end
			i_cpu.unlock(8'h86);
			stall_wait();
			check_len(n, WC);
		end
		i_cpu.wr(ADDR_PTR_LO, 8'h00);
		i_cpu.wr(ADDR_PTR_HI, 8'h00);
		for (int i = 0; i < 64; i++) rd_exp(ADDR_RDATA, row[i], 8'hFF);
		repeat (4) @(posedge clk);
		tally_and_finish();
	end
endmodule
